/* logic/dhr_pkg.sv */
// Shared constants, types and helpers for the host response/message block
package dhr_pkg;

  // Command and message codes, bits 5:0 of every host command and reply
  localparam logic [5:0] CODE_SET_CFG0 = 6'h01;
  localparam logic [5:0] CODE_GET_CFG0 = 6'h02;
  localparam logic [5:0] CODE_SET_CFG1 = 6'h03;
  localparam logic [5:0] CODE_GET_CFG1 = 6'h04;
  localparam logic [5:0] CODE_STATUS0  = 6'h05;
  localparam logic [5:0] CODE_STATUS1  = 6'h06;
  localparam logic [5:0] CODE_SET_CFG2 = 6'h07;
  localparam logic [5:0] CODE_GET_CFG2 = 6'h08;

  // Host command bytes carry this pattern in bits 7:6
  localparam logic [1:0] CMD_TAG       = 2'h2;

  // Reset values
  localparam logic [7:0] CFG0_RST      = 8'h00;
  localparam logic [7:0] DAC_RST       = 8'h40;
  localparam logic [7:0] CFG2_RST      = 8'h00;
  localparam logic [7:0] STAT0_RST     = 8'h00;
  localparam logic [7:0] STAT1_RST     = 8'h10;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Field layout helpers
  localparam logic [7:0] CFG0_RSVD_MASK = 8'h80;
  localparam logic [7:0] CFG2_RSVD_MASK = 8'hE0;
  localparam int         S1_EXT_UVLO    = 2;
  localparam int         S1_EXT_OC      = 3;
  localparam int         S1_BOR         = 4;
  localparam int         S1_LDO_UVLO    = 5;

  // DAC reference scale, for software: volts = base + code * step
  localparam int         DAC_STEP_UV    = 13770;
  localparam int         DAC_BASE_MV    = 991;

  // Configuration 0 byte
  typedef struct packed {
    logic       rsvd;         // Always zero
    logic       keep_pullup;  // 1 = pull-up stays on with chip-enable low
    logic       sleep_sel;    // 1 = sleep, 0 = standby with chip-enable low
    logic       neusim_en;    // Neutral simulator enable
    logic       uvlo_dis;     // External MOSFET undervoltage lockout off
    logic       oc_dis;       // External MOSFET overcurrent detect off
    logic [1:0] oc_lvl;       // Overcurrent threshold 0.250V..1.000V
  } dhr_cfg0_t;

  // First byte of every reply
  typedef struct packed {
    logic       unsol;
    logic       ack;
    logic [5:0] code;
  } dhr_hdr_t;

  // Raw fault levels from the analog supervisors
  typedef struct packed {
    logic [7:0] supply;       // Status 0 flags, bit for bit
    logic       ext_uvlo;
    logic       ext_oc;
    logic       ldo_uvlo;
    logic       bor;          // Brown-out lost configuration
  } dhr_fault_in_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARG  = 4'b0010,
    ST_HDR  = 4'b0100,
    ST_DAT  = 4'b1000
  } dhr_state_t;

  // Reply header from its three parts
  function automatic logic [7:0] dhr_make_hdr(input logic unsol, input logic ack,
                                              input logic [5:0] code);
    dhr_hdr_t h;
    h.unsol = unsol;
    h.ack   = ack;
    h.code  = code;
    return h;
  endfunction : dhr_make_hdr

  // True for commands that carry a payload byte
  function automatic logic dhr_is_set(input logic [5:0] code);
    return (code == CODE_SET_CFG0) || (code == CODE_SET_CFG1) || (code == CODE_SET_CFG2);
  endfunction : dhr_is_set

endpackage : dhr_pkg

/* logic/dhr_cfg_regs.sv */
// Configuration storage: configuration 0, DAC reference and configuration 2
`timescale 1ns/10ps
module dhr_cfg_regs
  import dhr_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write strobes and data
  input  wire logic       wr_cfg0,
  input  wire logic       wr_dac,
  input  wire logic       wr_cfg2,
  input  wire logic [7:0] wdata,
  // Stored values
  output dhr_cfg0_t       cfg0,
  output logic      [7:0] dac,
  output logic      [7:0] cfg2
);

  dhr_cfg0_t  cfg0_reg, cfg0_next;
  logic [7:0] dac_reg,  dac_next;
  logic [7:0] cfg2_reg, cfg2_next;

  // Reserved bits are dropped on write so they always read back as zero
  always_comb
  begin
    cfg0_next = cfg0_reg;
    dac_next  = dac_reg;
    cfg2_next = cfg2_reg;
    if (wr_cfg0)
      cfg0_next = wdata & ~CFG0_RSVD_MASK;
    if (wr_dac)
      dac_next  = wdata;
    if (wr_cfg2)
      cfg2_next = wdata & ~CFG2_RSVD_MASK;
  end

  // Register stage; start-up defaults put every feature in its safe state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg0_reg <= CFG0_RST;
      dac_reg  <= DAC_RST;
      cfg2_reg <= CFG2_RST;
    end
    else
    begin
      cfg0_reg <= cfg0_next;
      dac_reg  <= dac_next;
      cfg2_reg <= cfg2_next;
    end
  end

  assign cfg0 = cfg0_reg;
  assign dac  = dac_reg;
  assign cfg2 = cfg2_reg;

endmodule : dhr_cfg_regs

/* logic/dhr_fault_latch.sv */
// Sticky fault latches for the two status bytes, with unsolicited-report flags
`timescale 1ns/10ps
module dhr_fault_latch
  import dhr_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Raw fault levels
  input  dhr_fault_in_t      faults,
  // Clear after a status byte went out; mask is the byte that was sent
  input  wire logic          clr0,
  input  wire logic          clr1,
  input  wire logic    [7:0] clr_mask,
  // Latched bytes and report requests
  output logic         [7:0] stat0,
  output logic         [7:0] stat1,
  output logic               pend0,
  output logic               pend1
);

  logic [7:0] s0_reg, s0_next;
  logic [7:0] s1_reg, s1_next;
  logic       p0_reg, p0_next;
  logic       p1_reg, p1_next;
  logic [7:0] raw1;

  // Only the sent bits are cleared, and a live fault sets again at once,
  // so an event in the clearing cycle is never lost
  always_comb
  begin
    raw1              = BYTE_ZERO;
    raw1[S1_EXT_UVLO] = faults.ext_uvlo;
    raw1[S1_EXT_OC]   = faults.ext_oc;
    raw1[S1_BOR]      = faults.bor;
    raw1[S1_LDO_UVLO] = faults.ldo_uvlo;
    s0_next = faults.supply | (s0_reg & ~(clr0 ? clr_mask : BYTE_ZERO));
    s1_next = raw1 | (s1_reg & ~(clr1 ? clr_mask : BYTE_ZERO));
    p0_next = (|(faults.supply & ~s0_reg)) | (p0_reg & ~clr0);
    p1_next = (|(raw1 & ~s1_reg)) | (p1_reg & ~clr1);
  end

  // Brown-out flag reads one after start-up
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s0_reg <= STAT0_RST;
      s1_reg <= STAT1_RST;
      p0_reg <= 1'b0;
      p1_reg <= 1'b0;
    end
    else
    begin
      s0_reg <= s0_next;
      s1_reg <= s1_next;
      p0_reg <= p0_next;
      p1_reg <= p1_next;
    end
  end

  assign stat0 = s0_reg;
  assign stat1 = s1_reg;
  assign pend0 = p0_reg;
  assign pend1 = p1_reg;

endmodule : dhr_fault_latch

/* logic/dhr_host_msg.sv */
// Host command interpreter: replies, unsolicited status and power-mode outputs
// What this block does
// - Set-config-0 replies 01H when rejected, 41H when accepted.
// - Get-config-0 replies 02H or 42H, then the config-0 byte.
// - Bit 6 keeps pull-up on with chip-enable low; ignored in sleep.
// - Bit 5 picks sleep over standby; sleep always disconnects pull-up.
// - Bit 4 enables neutral simulator; starts at zero.
// - Bit 3 set disables external MOSFET undervoltage lockout; default zero.
// - Bit 2 set disables external MOSFET overcurrent detection; default zero.
// - Bits 1:0 pick overcurrent threshold 0.250V to 1.000V; default 00.
// - Set-config-1 replies 03H or 43H, then the DAC reference byte.
// - Get-config-1 replies 04H or 44H, then the DAC reference byte.
// - DAC byte spans 00H-FFH, 13.77 mV per step above 0.991V.
// - Status-0 request replies 05H or 45H, then the status-0 byte.
// - Device may send status 0 unprompted as 85H plus the byte.
// - Status-0 low bits: temperature, overtemp, input UV, driver OV, input OV.
// - Status-0 high bits: buck overcurrent, buck UV warning, buck brown-out.
// - Status-1 request replies 06H or 46H; unprompted status 1 is 86H.
// - Status-1 bits 2,3,5: MOSFET UVLO, MOSFET overcurrent, 5V LDO UVLO.
// - Status-1 bit 4 marks configuration lost; reads one after start-up.
`timescale 1ns/10ps
module dhr_host_msg
  import dhr_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Bytes received from the host serial port
  input  wire logic          rx_valid,
  input  wire logic    [7:0] rx_byte,
  // Bytes to the host serial port
  input  wire logic          tx_ready,
  output logic               tx_valid,
  output logic         [7:0] tx_byte,
  // Device state
  input  wire logic          chip_en,
  input  dhr_fault_in_t      faults,
  // Configuration outputs
  output dhr_cfg0_t          cfg0_out,
  output logic         [7:0] dac_ref,
  output logic         [7:0] cfg2_out,
  output logic               pullup_on,
  output logic               sleep_active,
  output logic               standby_active
);

  dhr_state_t state_reg, state_next;
  logic [5:0] code_reg,  code_next;
  logic       ack_reg,   ack_next;
  logic       unsol_reg, unsol_next;
  logic [7:0] dat_reg,   dat_next;
  logic       txv_reg,   txv_next;
  logic [7:0] txb_reg,   txb_next;
  logic       pu_reg,    pu_next;
  logic       slp_reg,   slp_next;
  logic       stb_reg,   stb_next;

  logic       wr_cfg0, wr_dac, wr_cfg2;
  logic       clr0, clr1;
  logic       pend0, pend1;
  logic [7:0] stat0, stat1;
  logic [7:0] cfg2;
  logic [7:0] dac;
  dhr_cfg0_t  cfg0;
  logic       rx_cmd;
  logic       arg_ok;
  logic       tx_done;

  dhr_cfg_regs u_cfg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_cfg0 (wr_cfg0),
    .wr_dac  (wr_dac),
    .wr_cfg2 (wr_cfg2),
    .wdata   (rx_byte),
    .cfg0    (cfg0),
    .dac     (dac),
    .cfg2    (cfg2)
  );

  dhr_fault_latch u_flt (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .faults   (faults),
    .clr0     (clr0),
    .clr1     (clr1),
    .clr_mask (dat_reg),
    .stat0    (stat0),
    .stat1    (stat1),
    .pend0    (pend0),
    .pend1    (pend1)
  );

  // Current payload for a code; set commands return the value just written, or the stored value when refused
  function automatic logic [7:0] payload(input logic [5:0] code, input logic [7:0] wval,
                                         input logic ok);
    case (code)
      CODE_SET_CFG0: payload = ok ? (wval & ~CFG0_RSVD_MASK) : cfg0;
      CODE_GET_CFG0: payload = cfg0;
      CODE_SET_CFG1: payload = ok ? wval : dac;
      CODE_GET_CFG1: payload = dac;
      CODE_STATUS0:  payload = stat0;
      CODE_STATUS1:  payload = stat1;
      CODE_SET_CFG2: payload = ok ? (wval & ~CFG2_RSVD_MASK) : cfg2;
      CODE_GET_CFG2: payload = cfg2;
      default:       payload = BYTE_ZERO;
    endcase
  endfunction : payload

  // Command decode; a byte without the command tag or with an unknown code is dropped
  always_comb
  begin
    rx_cmd = rx_valid && (rx_byte[7:6] == CMD_TAG) &&
             (rx_byte[5:0] >= CODE_SET_CFG0) && (rx_byte[5:0] <= CODE_GET_CFG2);
    // A payload with reserved bits set is refused and nothing is stored
    case (code_reg)
      CODE_SET_CFG0: arg_ok = (rx_byte & CFG0_RSVD_MASK) == BYTE_ZERO;
      CODE_SET_CFG2: arg_ok = (rx_byte & CFG2_RSVD_MASK) == BYTE_ZERO;
      default:       arg_ok = 1'b1;
    endcase
    tx_done = txv_reg && tx_ready;
  end

  // Write strobes fire on the payload byte of an accepted set command
  assign wr_cfg0 = (state_reg == ST_ARG) && rx_valid && arg_ok && (code_reg == CODE_SET_CFG0);
  assign wr_dac  = (state_reg == ST_ARG) && rx_valid && (code_reg == CODE_SET_CFG1);
  assign wr_cfg2 = (state_reg == ST_ARG) && rx_valid && arg_ok && (code_reg == CODE_SET_CFG2);
  // Status clears only once the data byte has gone out
  assign clr0 = (state_reg == ST_DAT) && tx_done && (code_reg == CODE_STATUS0);
  assign clr1 = (state_reg == ST_DAT) && tx_done && (code_reg == CODE_STATUS1);

  // Reply sequencer; bytes from the host during a reply are ignored,
  // the host is expected to wait for the two-byte answer
  always_comb
  begin
    state_next = state_reg;
    code_next  = code_reg;
    ack_next   = ack_reg;
    unsol_next = unsol_reg;
    dat_next   = dat_reg;
    txv_next   = txv_reg;
    txb_next   = txb_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (rx_cmd)
        begin
          code_next  = rx_byte[5:0];
          unsol_next = 1'b0;
          ack_next   = 1'b1;
          if (dhr_is_set(rx_byte[5:0]))
            state_next = ST_ARG;
          else
          begin
            dat_next   = payload(rx_byte[5:0], BYTE_ZERO, 1'b0);
            txv_next   = 1'b1;
            txb_next   = dhr_make_hdr(1'b0, 1'b1, rx_byte[5:0]);
            state_next = ST_HDR;
          end
        end
        // Unsolicited reports only start in a cycle with no command byte from the host
        else if (pend0 || pend1)
        begin
          code_next  = pend0 ? CODE_STATUS0 : CODE_STATUS1;
          unsol_next = 1'b1;
          ack_next   = 1'b0;
          dat_next   = pend0 ? stat0 : stat1;
          txv_next   = 1'b1;
          txb_next   = dhr_make_hdr(1'b1, 1'b0, pend0 ? CODE_STATUS0 : CODE_STATUS1);
          state_next = ST_HDR;
        end
      end
      ST_ARG:
      begin
        if (rx_valid)
        begin
          ack_next   = arg_ok;
          dat_next   = payload(code_reg, rx_byte, arg_ok);
          txv_next   = 1'b1;
          txb_next   = dhr_make_hdr(1'b0, arg_ok, code_reg);
          state_next = ST_HDR;
        end
      end
      ST_HDR:
      begin
        if (tx_done)
        begin
          txb_next   = dat_reg;
          state_next = ST_DAT;
        end
      end
      ST_DAT:
      begin
        if (tx_done)
        begin
          txv_next   = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        txv_next   = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  // Low-power outputs; sleep overrides the pull-up keep bit
  always_comb
  begin
    slp_next = !chip_en && cfg0.sleep_sel;
    stb_next = !chip_en && !cfg0.sleep_sel;
    pu_next  = chip_en || (cfg0.keep_pullup && !cfg0.sleep_sel);
  end

  // Register stage for sequencer and outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      code_reg  <= CODE_SET_CFG0;
      ack_reg   <= 1'b0;
      unsol_reg <= 1'b0;
      dat_reg   <= BYTE_ZERO;
      txv_reg   <= 1'b0;
      txb_reg   <= BYTE_ZERO;
      pu_reg    <= 1'b1;
      slp_reg   <= 1'b0;
      stb_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      code_reg  <= code_next;
      ack_reg   <= ack_next;
      unsol_reg <= unsol_next;
      dat_reg   <= dat_next;
      txv_reg   <= txv_next;
      txb_reg   <= txb_next;
      pu_reg    <= pu_next;
      slp_reg   <= slp_next;
      stb_reg   <= stb_next;
    end
  end

  // Configuration bits drive the analog side straight from their flops
  assign cfg0_out       = cfg0;
  assign dac_ref        = dac;
  assign cfg2_out       = cfg2;
  assign tx_valid       = txv_reg;
  assign tx_byte        = txb_reg;
  assign pullup_on      = pu_reg;
  assign sleep_active   = slp_reg;
  assign standby_active = stb_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_set0_nack;
    (state_reg == ST_ARG) && (code_reg == CODE_SET_CFG0) && rx_valid && rx_byte[7]
      |=> tx_valid && (tx_byte == 8'h01) && $stable(cfg0);
  endproperty
  a_set0_nack: assert property (p_set0_nack) else $error("set cfg0 reject not 01H");

  property p_set0_ack;
    (state_reg == ST_ARG) && (code_reg == CODE_SET_CFG0) && rx_valid && !rx_byte[7]
      |=> tx_valid && (tx_byte == 8'h41) && (cfg0 == $past(rx_byte));
  endproperty
  a_set0_ack: assert property (p_set0_ack) else $error("set cfg0 accept wrong");

  property p_get0;
    (state_reg == ST_IDLE) && rx_valid && (rx_byte == 8'h82)
      |=> tx_valid && (tx_byte == 8'h42) && (dat_reg == cfg0);
  endproperty
  a_get0: assert property (p_get0) else $error("get cfg0 reply wrong");

  property p_rsvd;
    cfg0.rsvd == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("cfg0 reserved bit set");

  property p_sleep_pullup;
    !chip_en && cfg0.sleep_sel ##1 !chip_en |-> !pullup_on && sleep_active;
  endproperty
  a_sleep_pullup: assert property (p_sleep_pullup) else $error("sleep kept pull-up");

  property p_dac_echo;
    (state_reg == ST_HDR) && tx_ready && (code_reg == CODE_SET_CFG1)
      |=> (tx_byte == dac_ref) && tx_valid;
  endproperty
  a_dac_echo: assert property (p_dac_echo) else $error("DAC echo wrong");

  property p_unsol0;
    (state_reg == ST_IDLE) && !rx_cmd && pend0 |=> tx_valid && (tx_byte == 8'h85);
  endproperty
  a_unsol0: assert property (p_unsol0) else $error("unsolicited status 0 not 85H");

  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte changed while stalled");

  property p_bor;
    @(posedge ref_clk) $fell(rst) |-> stat1[S1_BOR];
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out flag clear after reset");

endmodule : dhr_host_msg

/* verification/dhr_host_model.sv */
// Host controller model: sends request bytes and takes reply bytes
`timescale 1ns/10ps
module dhr_host_model
(
  // Clock
  input  wire logic ref_clk,
  // Bytes to the device
  output logic      rx_valid,
  output logic [7:0] rx_byte,
  // Reply side
  output logic      tx_ready,
  input  wire logic slow
);
  // Request bytes the host uses for status and configuration 2
  localparam logic [7:0] REQ_STAT0 = 8'h85;
  localparam logic [7:0] REQ_STAT1 = 8'h86;
  localparam logic [7:0] REQ_CFG2  = 8'h88;

  integer seed = 35538;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b1;
  end

  // Random stalls in slow mode, so held replies are exercised
  always @(negedge ref_clk)
    tx_ready <= !slow || (($random(seed) & 1) == 1);

  // One byte per cycle; an idle line shows the inverse of the last byte
  task automatic send(input int n, input logic [7:0] b0, input logic [7:0] b1);
    @(negedge ref_clk);
    rx_valid <= 1'b1;
    rx_byte  <= b0;
    if (n > 1)
    begin
      @(negedge ref_clk);
      rx_byte <= b1;
    end
    @(negedge ref_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~rx_byte;
  endtask : send
endmodule : dhr_host_model

/* verification/dhr_host_msg_bench.sv */
// Self-checking bench for the host response and message block
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
      n_fail++; \
    end \
  end
module dhr_host_msg_bench
  import dhr_pkg::*;
;
  logic          ref_clk;
  logic          rst;
  logic          rx_valid;
  logic    [7:0] rx_byte;
  logic          tx_ready;
  logic          tx_valid;
  logic    [7:0] tx_byte;
  logic          chip_en;
  dhr_fault_in_t faults;
  dhr_cfg0_t     cfg0_out;
  logic    [7:0] dac_ref;
  logic    [7:0] cfg2_out;
  logic          pullup_on;
  logic          sleep_active;
  logic          standby_active;
  logic          slow;
  logic    [7:0] exp_q[$];
  logic    [7:0] got_exp;
  logic    [7:0] p;
  logic    [7:0] s1_exp[4] = '{8'h04, 8'h08, 8'h20, 8'h10};
  int            n_fail = 0;
  int            compares = 0;

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  dhr_host_msg uut (
    .ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .chip_en(chip_en), .faults(faults), .cfg0_out(cfg0_out), .dac_ref(dac_ref),
    .cfg2_out(cfg2_out), .pullup_on(pullup_on), .sleep_active(sleep_active),
    .standby_active(standby_active));

  dhr_host_model host (
    .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .slow(slow));

  // Each byte the host takes is matched with the oldest note; a spare byte fails
  always @(posedge ref_clk)
    if (rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      got_exp = (exp_q.size() != 0) ? exp_q.pop_front() : ~tx_byte;
      `CHK("tx_byte", got_exp, tx_byte)
    end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Bounded wait until every noted byte has gone out
  task automatic drain();
    int i;
    for (i = 0; i < 100 && (exp_q.size() != 0 || tx_valid !== 1'b0); i++)
      @(negedge ref_clk);
    if (i == 100)
    begin
      $display("ERROR drain expected %h seen %h", 0, exp_q.size());
      n_fail++;
      final_report();
    end
  endtask : drain

  // Note the two reply bytes, then let the host send the request
  task automatic cmd(input int n, input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] e0, input logic [7:0] e1);
    exp_q.push_back(e0);
    exp_q.push_back(e1);
    host.send(n, c, d);
    drain();
  endtask : cmd

  initial
  begin
    rst     = 1'b1;
    chip_en = 1'b1;
    faults  = '0;
    slow    = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    // Start-up values
    `CHK("cfg0_out", 8'h00, cfg0_out)
    `CHK("dac_ref", 8'h40, dac_ref)
    cmd(1, 8'h82, 8'h00, 8'h42, 8'h00);
    cmd(1, 8'h84, 8'h00, 8'h44, 8'h40);
    cmd(1, host.REQ_STAT1, 8'h00, 8'h46, 8'h10);
    cmd(1, host.REQ_STAT1, 8'h00, 8'h46, 8'h00);
    cmd(1, host.REQ_STAT0, 8'h00, 8'h45, 8'h00);
    cmd(1, host.REQ_CFG2, 8'h00, 8'h48, 8'h00);
    $display("Test start-up values done");
    // Walking ones then random fields, with the host stalling
    slow = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      p = (i < 7) ? (8'h01 << i) : {1'b0, 7'($random(host.seed))};
      cmd(2, 8'h81, p, 8'h41, p);
      `CHK("cfg0_out", p, cfg0_out)
      cmd(1, 8'h82, 8'h00, 8'h42, p);
    end
    cmd(2, 8'h81, 8'h80 | 8'($random(host.seed)), 8'h01, p);
    `CHK("cfg0_out", p, cfg0_out)
    $display("Test configuration 0 done");
    for (int i = 0; i < 6; i++)
    begin
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(host.seed));
      cmd(2, 8'h83, p, 8'h43, p);
      `CHK("dac_ref", p, dac_ref)
      cmd(1, 8'h84, 8'h00, 8'h44, p);
    end
    cmd(2, 8'h87, 8'h1F, 8'h47, 8'h1F);
    cmd(2, 8'h87, 8'hA0, 8'h07, 8'h1F);
    cmd(1, host.REQ_CFG2, 8'h00, 8'h48, 8'h1F);
    `CHK("cfg2_out", 8'h1F, cfg2_out)
    // Stray bytes, and a request during a reply, draw no answer
    host.send(2, 8'h55, 8'h80);
    host.send(2, 8'h89, 8'hC2);
    cmd(2, 8'h84, 8'h82, 8'h44, p);
    $display("Test reference and stray bytes done");
    // Power-mode outputs for every pull-up, sleep and chip-enable mix
    slow = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      p = {1'b0, i[1], i[0], 5'h00};
      cmd(2, 8'h81, p, 8'h41, p);
      chip_en = i[2];
      repeat (2) @(negedge ref_clk);
      `CHK("pullup_on", i[2] | (i[1] & !i[0]), pullup_on)
      `CHK("sleep_active", !i[2] & i[0], sleep_active)
      `CHK("standby_active", !i[2] & !i[0], standby_active)
    end
    chip_en = 1'b1;
    $display("Test power modes done");
    // One-cycle fault pulses, each reported unasked, then cleared
    for (int i = 0; i < 12; i++)
    begin
      exp_q.push_back((i < 8) ? 8'h85 : 8'h86);
      exp_q.push_back((i < 8) ? (8'h01 << i) : s1_exp[i - 8]);
      faults = 12'h001 << ((i < 8) ? i + 4 : 11 - i);
      @(negedge ref_clk);
      faults = '0;
      drain();
    end
    cmd(1, host.REQ_STAT0, 8'h00, 8'h45, 8'h00);
    cmd(1, host.REQ_STAT1, 8'h00, 8'h46, 8'h00);
    $display("Test fault reports done");
    // A reset in mid-run restores the start-up state
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    `CHK("dac_ref", 8'h40, dac_ref)
    cmd(1, host.REQ_STAT1, 8'h00, 8'h46, 8'h10);
    $display("Test second reset done");
    final_report();
  end
endmodule : dhr_host_msg_bench
